/* File: core/mmpc_pin_ctrl.sv */
// Purpose: sixteen configurable pins with input, output and alarm modes behind APB
// Assumes: pll_locked and ref_sig_absent come from logic on mclk; pin_in is asynchronous
// Notes:   zero-wait APB slave, read data latched in the setup cycle
//
// Behaviour
// - each pin has its own mode, applied only after the reset sequence ends
// - sixteen pin instances, 0 to 15, each with its own register
// - input mode: pin level readable in a status register
// - unprogrammed pins default to general input mode
// - output mode: pin driven to the level held in its control register
// - pins with identical alarm settings give identical outputs
// - signal-absent mode drives the live monitor alarm, active high, never sticky
// - signal-absent pin polarity can be inverted by a register bit
// - registers select which reference monitor drives a signal-absent pin
// - registers select which pll channel drives a lock-fail pin
// - live lock-fail mode drives high while the selected pll is unlocked
// - sticky lock-fail mode drives high after any lock status change
// - lock-fail pin polarity can be inverted so low signals unlock (live mode) or a change (sticky mode)
// - sticky lock indication holds until host writes the clear register
// - alert mode ORs enabled sticky bits, falls only when all are clear
// - each sticky bit sets on alarm change and holds until cleared
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module mmpc_pin_ctrl (
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    // apb slave
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [mmpc_pkg::AW-1:0]      paddr,
    input  wire logic [31:0]                  pwdata,
    output logic                              pready,
    output logic [31:0]                       prdata,
    output logic                              pslverr,
    // device status
    input  wire logic                         reset_done,
    input  wire logic [mmpc_pkg::NPLL-1:0]    pll_locked,
    input  wire logic [mmpc_pkg::NREF-1:0]    ref_sig_absent,
    // pins
    input  wire logic [mmpc_pkg::NPIN-1:0]    pin_in,
    output logic [mmpc_pkg::NPIN-1:0]         pin_out,
    output logic [mmpc_pkg::NPIN-1:0]         pin_oe_n,
    // interrupt
    output logic                              irq
);

    typedef struct packed {
        logic [mmpc_pkg::NPIN-1:0][mmpc_pkg::CTRL_W-1:0] ctrl;
        logic [mmpc_pkg::NPIN-1:0]                       s1;
        logic [mmpc_pkg::NPIN-1:0]                       s2;
        logic [mmpc_pkg::NPIN-1:0]                       s3;
        logic [mmpc_pkg::NPIN-1:0]                       pin_val;
        logic [mmpc_pkg::NPLL-1:0]                       lock_prev;
        logic [mmpc_pkg::NREF-1:0]                       sig_prev;
        logic [mmpc_pkg::NSTK-1:0]                       sticky;
        logic [mmpc_pkg::NSTK-1:0]                       mask;
        logic [mmpc_pkg::NSTK-1:0]                       alert_en;
        logic                                            active;
        logic [mmpc_pkg::NPIN-1:0]                       pout;
        logic [mmpc_pkg::NPIN-1:0]                       poe_n;
        logic [31:0]                                     rdata;
        logic                                            slverr;
        logic                                            irq;
    } mmpc_state_t;

    mmpc_state_t st_r;
    mmpc_state_t st_nxt;

    // true when the address names a register of this block
    function automatic logic addr_hit(input logic [mmpc_pkg::AW-1:0] a);
        logic ok;
        ok = 1'b0;
        if (a[1:0] == 2'h0) begin
            if (a <= mmpc_pkg::A_CTRL_END) begin
                ok = 1'b1;
            end else if (a == mmpc_pkg::A_PIN_IN || a == mmpc_pkg::A_STICKY ||
                         a == mmpc_pkg::A_IRQ_MASK || a == mmpc_pkg::A_ALERT_EN ||
                         a == mmpc_pkg::A_LIVE) begin
                ok = 1'b1;
            end
        end
        return ok;
    endfunction

    // level that one pin carries in its alarm or output mode
    // the result depends only on the control word and shared sources, so
    // equally configured pins can never disagree
    function automatic logic pin_level(
        input logic [mmpc_pkg::CTRL_W-1:0] c,
        input logic [mmpc_pkg::NPLL-1:0]   lk,
        input logic [mmpc_pkg::NREF-1:0]   sa,
        input logic [mmpc_pkg::NSTK-1:0]   stk,
        input logic [mmpc_pkg::NSTK-1:0]   aen);
        logic [2:0] md;
        logic [2:0] sel;
        logic [1:0] psel_ch;
        logic       raw;
        md      = c[mmpc_pkg::F_MODE +: 3];
        sel     = c[mmpc_pkg::F_SEL +: 3];
        psel_ch = sel[1:0];
        raw     = 1'b0;
        unique case (md)
            mmpc_pkg::MODE_OUT:       raw = c[mmpc_pkg::F_OUT];
            mmpc_pkg::MODE_SIG:       raw = sa[sel];
            mmpc_pkg::MODE_LOCK_LIVE: raw = ~lk[psel_ch];
            mmpc_pkg::MODE_LOCK_STK:  raw = stk[psel_ch];
            mmpc_pkg::MODE_ALERT:     raw = |(stk & aen);
            default:                  raw = 1'b0;
        endcase
        if (md != mmpc_pkg::MODE_OUT && md != mmpc_pkg::MODE_IN && c[mmpc_pkg::F_INV]) begin
            raw = ~raw;
        end
        return raw;
    endfunction

    // next-state logic for the whole block
    always_comb begin
        logic [mmpc_pkg::NSTK-1:0] ev;
        logic [mmpc_pkg::NSTK-1:0] clr;
        logic                      setup;
        logic                      wr;
        logic                      hit;
        logic [3:0]                idx;
        logic [2:0]                md;
        logic [31:0]               rd;
        ev     = '0;
        clr    = '0;
        setup  = psel & ~penable;
        wr     = psel & penable & pwrite;
        hit    = addr_hit(paddr);
        idx    = paddr[5:2];
        md     = 3'h0;
        rd     = 32'h0000_0000;
        st_nxt = st_r;

        // three-flop chain, level taken when stages two and three agree
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < mmpc_pkg::NPIN; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.pin_val[i] = st_r.s3[i];
            end
        end

        st_nxt.lock_prev = pll_locked;
        st_nxt.sig_prev  = ref_sig_absent;
        // events are ignored until the reset sequence is over
        if (st_r.active) begin
            ev = {ref_sig_absent ^ st_r.sig_prev, pll_locked ^ st_r.lock_prev};
        end

        // modes take effect once reset sequence completes
        st_nxt.active = st_r.active | reset_done;

        // register writes in the access cycle
        if (wr && hit) begin
            if (paddr <= mmpc_pkg::A_CTRL_END) begin
                st_nxt.ctrl[idx] = pwdata[mmpc_pkg::CTRL_W-1:0];
            end else if (paddr == mmpc_pkg::A_STICKY) begin
                clr = pwdata[mmpc_pkg::NSTK-1:0];
            end else if (paddr == mmpc_pkg::A_IRQ_MASK) begin
                st_nxt.mask = pwdata[mmpc_pkg::NSTK-1:0];
            end else if (paddr == mmpc_pkg::A_ALERT_EN) begin
                st_nxt.alert_en = pwdata[mmpc_pkg::NSTK-1:0];
            end
        end

        // set on change, held until write-one clear
        // set wins over a clear in the same cycle
        st_nxt.sticky = (st_r.sticky & ~clr) | ev;

        // level interrupt from unmasked sticky bits
        st_nxt.irq = |(st_nxt.sticky & st_r.mask);

        // pin drivers, registered so pins never glitch from decode
        for (int i = 0; i < mmpc_pkg::NPIN; i++) begin
            md = st_r.ctrl[i][mmpc_pkg::F_MODE +: 3];
            // pins stay undriven inputs until active or in input mode
            if (!st_r.active || md == mmpc_pkg::MODE_IN || md > mmpc_pkg::MODE_ALERT) begin
                st_nxt.poe_n[i] = 1'b1;
                st_nxt.pout[i]  = 1'b0;
            end else begin
                st_nxt.poe_n[i] = 1'b0;
                st_nxt.pout[i]  = pin_level(st_r.ctrl[i], pll_locked, ref_sig_absent,
                                            st_r.sticky, st_r.alert_en);
            end
        end

        // read data latched in the setup cycle, so access needs no wait
        if (setup) begin
            if (paddr <= mmpc_pkg::A_CTRL_END) begin
                rd[mmpc_pkg::CTRL_W-1:0] = st_r.ctrl[idx];
            end else if (paddr == mmpc_pkg::A_PIN_IN) begin
                rd[mmpc_pkg::NPIN-1:0] = st_r.pin_val;
            end else if (paddr == mmpc_pkg::A_STICKY) begin
                rd[mmpc_pkg::NSTK-1:0] = st_r.sticky;
            end else if (paddr == mmpc_pkg::A_IRQ_MASK) begin
                rd[mmpc_pkg::NSTK-1:0] = st_r.mask;
            end else if (paddr == mmpc_pkg::A_ALERT_EN) begin
                rd[mmpc_pkg::NSTK-1:0] = st_r.alert_en;
            end else if (paddr == mmpc_pkg::A_LIVE) begin
                rd[mmpc_pkg::NSTK-1:0] = {ref_sig_absent, ~pll_locked};
            end
            if (!hit || pwrite) begin
                rd = 32'h0000_0000;
            end
            st_nxt.rdata  = rd;
            st_nxt.slverr = ~hit;
        end
    end

    // state register; every field resets to a constant
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < mmpc_pkg::NPIN; i++) begin
                st_r.ctrl[i] <= mmpc_pkg::CTRL_RST;
            end
            st_r.s1        <= '0;
            st_r.s2        <= '0;
            st_r.s3        <= '0;
            st_r.pin_val   <= '0;
            st_r.lock_prev <= '0;
            st_r.sig_prev  <= '0;
            st_r.sticky    <= '0;
            st_r.mask      <= mmpc_pkg::MASK_RST;
            st_r.alert_en  <= mmpc_pkg::ALERT_RST;
            st_r.active    <= 1'b0;
            st_r.pout      <= '0;
            st_r.poe_n     <= '1;
            st_r.rdata     <= 32'h0000_0000;
            st_r.slverr    <= 1'b0;
            st_r.irq       <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs; pready is combinational, zero wait states
    assign pready   = psel & penable;
    assign prdata   = st_r.rdata;
    assign pslverr  = psel & penable & st_r.slverr;
    assign pin_out  = st_r.pout;
    assign pin_oe_n = st_r.poe_n;
    assign irq      = st_r.irq;

endmodule

/* File: core/mmpc_pkg.sv */
// Purpose: shared constants for the multi-mode pin controller
// Assumes: 32-bit APB register window, byte addresses, one word per register
// Notes:   mode codes sit in the low bits of each pin control word
package mmpc_pkg;

    // sizes
    localparam int NPIN = 16;           // configurable pins 0..15
    localparam int NREF = 8;            // reference monitors
    localparam int NPLL = 4;            // pll channels
    localparam int NSTK = NPLL + NREF;  // sticky bits: lock changes low, signal changes high
    localparam int AW   = 12;           // apb address width

    // register byte addresses
    localparam logic [AW-1:0] A_CTRL0    = 12'h000; // pin i control at A_CTRL0 + 4*i
    localparam logic [AW-1:0] A_CTRL_END = 12'h03C;
    localparam logic [AW-1:0] A_PIN_IN   = 12'h040; // synchronised pin levels, read only
    localparam logic [AW-1:0] A_STICKY   = 12'h044; // sticky alarm bits, write one to clear
    localparam logic [AW-1:0] A_IRQ_MASK = 12'h048; // interrupt enables per sticky bit
    localparam logic [AW-1:0] A_ALERT_EN = 12'h04C; // aggregated alert enables per sticky bit
    localparam logic [AW-1:0] A_LIVE     = 12'h050; // live lock-fail and signal-absent levels

    // pin control word fields
    localparam int F_MODE = 0;          // [2:0] mode
    localparam int F_INV  = 3;          // polarity inversion for alarm modes
    localparam int F_SEL  = 4;          // [6:4] source select
    localparam int F_OUT  = 7;          // output level in general output mode
    localparam int CTRL_W = 8;

    // mode codes
    localparam logic [2:0] MODE_IN        = 3'h0;
    localparam logic [2:0] MODE_OUT       = 3'h1;
    localparam logic [2:0] MODE_SIG       = 3'h2; // signal_absent_status, live only
    localparam logic [2:0] MODE_LOCK_LIVE = 3'h3; // lock_fail_status, live
    localparam logic [2:0] MODE_LOCK_STK  = 3'h4; // lock_fail_status, sticky
    localparam logic [2:0] MODE_ALERT     = 3'h5; // aggregated alert

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST  = 8'h00;  // general input
    localparam logic [NSTK-1:0]   MASK_RST  = 12'h000;
    localparam logic [NSTK-1:0]   ALERT_RST = 12'h000;

endpackage

/* File: tb/mmpc_chk_sva.sv */
// Purpose: port-level checks for the pin controller
// Assumes: sees top ports only; control words shadowed from apb writes
// Notes:   sticky timing is judged by the bench, not here
`timescale 1ns/1ps
module mmpc_chk (
    input wire logic        mclk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        reset_done,
    input wire logic [3:0]  pll_locked,
    input wire logic [7:0]  ref_sig_absent,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    input wire logic        irq
);
    logic [7:0]  ctl_r [16];
    logic        act_r;
    logic [15:0] live_r, drv_r, val_r;
    wire         acc = psel & penable;
    // shadow words; expected drive lags one edge like the pin register stage
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            act_r <= 1'b0;
            {live_r, drv_r, val_r} <= 48'h0;
            for (int i = 0; i < 16; i++) ctl_r[i] <= 8'h00;
        end else begin
            act_r <= act_r | reset_done;
            for (int i = 0; i < 16; i++) begin
                live_r[i] <= act_r && ctl_r[i][2:0] inside {3'h1, 3'h2, 3'h3};
                drv_r[i]  <= act_r && ctl_r[i][2:0] inside {[3'h1:3'h5]};
                val_r[i]  <= (ctl_r[i][2:0] == 3'h1) ? ctl_r[i][7] :
                             (ctl_r[i][2:0] == 3'h2) ? ref_sig_absent[ctl_r[i][6:4]] ^ ctl_r[i][3] :
                             !pll_locked[ctl_r[i][5:4]] ^ ctl_r[i][3];
                if (acc && pwrite && paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0
                    && paddr[5:2] == 4'(i)) ctl_r[i] <= pwdata[7:0];
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    a_ready_now:
        assert property (acc |-> pready) else $error("pready missing");
    a_err_unmapped:
        assert property (acc && paddr >= 12'h054 |-> pslverr) else $error("no slave error");
    a_err_quiet:
        assert property (acc && paddr < 12'h054 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("spurious slave error");
    a_idle_before:
        assert property (!act_r |=> pin_oe_n == 16'hFFFF) else $error("pin driven early");
    a_irq_before:
        assert property (!act_r |=> !irq) else $error("irq before active");
    a_drive_modes:
        assert property ((pin_oe_n & drv_r) == 16'h0000) else $error("pin not driven");
    a_input_undriven:
        assert property ((~pin_oe_n & ~drv_r) == 16'h0000) else $error("input pin driven");
    a_live_value:
        assert property (((pin_out ^ val_r) & live_r) == 16'h0000) else $error("live pin wrong");
    a_idle_low:
        assert property ((pin_out & ~drv_r) == 16'h0000) else $error("undriven pin not low");
    c_ctrl_write: cover property (acc && pwrite && paddr < 12'h040);
    c_irq_rise: cover property ($rose(irq));
    c_slv_err: cover property (pslverr);
endmodule
bind mmpc_pin_ctrl mmpc_chk i_chk (.*);

/* File: tb/mmpc_board.sv */
// Purpose: board logic wired to the sixteen pins
// Assumes: board drives every pin the block leaves undriven
// Notes:   wire level resolved from the block enable, no contention modelled
`timescale 1ns/1ps
module mmpc_board (
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe_n,
    input wire logic [15:0] drv,
    output logic     [15:0] pin_in
);
    // block wins where its active-low enable is asserted
    assign pin_in = (pin_out & ~pin_oe_n) | (drv & pin_oe_n);
endmodule

/* File: tb/tb_mmpc_pin_ctrl.sv */
// Purpose: self-checking bench for the pin controller
// Assumes: zero-wait apb slave, board model on the pins
// Notes:   each scenario judges its own results
`timescale 1ns/1ps
module tb_mmpc_pin_ctrl;
    logic        mclk, rstn, psel, penable, pwrite, pready, pslverr, reset_done, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pll_locked;
    logic [7:0]  ref_sig_absent;
    logic [15:0] pin_in, pin_out, pin_oe_n, drv;
    int          err_count = 0;
    int          cmp_count = 0;
    mmpc_pin_ctrl i_dut (.*);
    mmpc_board i_board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .drv(drv), .pin_in(pin_in));
    // clock source
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // only the watchdog ends a hung wait
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        chk("slverr", {31'h0, a >= 12'h054}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic t_input;
        chk("oe_default", 32'hFFFF, pin_oe_n);
        @(posedge mclk);
        drv <= 16'hA5C3;
        tk(6);
        apb(1'b0, 12'h040, 32'h0);
        chk("pin_level", 32'hA5C3, rd);
        apb(1'b0, 12'h060, 32'h0);
        chk("unmapped_rd", 32'h0, rd);
    endtask
    task automatic t_output;
        apb(1'b1, 12'h004, 32'h81);
        apb(1'b1, 12'h008, 32'h01);
        tk(1);
        chk("out_level", 32'h1, pin_out[2:1]);
        chk("out_oe", 32'h0, pin_oe_n[2:1]);
        apb(1'b0, 12'h004, 32'h0);
        chk("ctrl_rd", 32'h81, rd);
    endtask
    task automatic t_live;
        apb(1'b1, 12'h00C, 32'h23);
        apb(1'b1, 12'h010, 32'h52);
        apb(1'b1, 12'h014, 32'h52);
        apb(1'b1, 12'h018, 32'h5A);
        apb(1'b1, 12'h01C, 32'h2B);
        @(posedge mclk);
        ref_sig_absent <= 8'h20;
        pll_locked <= 4'hB;
        tk(2);
        chk("live_a", 32'h07, pin_out[7:3]);
        @(posedge mclk);
        ref_sig_absent <= 8'h00;
        pll_locked <= 4'hF;
        tk(2);
        chk("live_b", 32'h18, pin_out[7:3]);
    endtask
    task automatic t_sticky;
        apb(1'b1, 12'h020, 32'h14);
        apb(1'b1, 12'h024, 32'h1C);
        apb(1'b1, 12'h048, 32'h002);
        apb(1'b1, 12'h044, 32'hFFF);
        tk(2);
        chk("stk_idle", 32'h2, {irq, pin_out[9:8]});
        @(posedge mclk);
        pll_locked <= 4'hD;
        tk(2);
        chk("stk_set", 32'h5, {irq, pin_out[9:8]});
        @(posedge mclk);
        pll_locked <= 4'hF;
        tk(3);
        apb(1'b0, 12'h044, 32'h0);
        chk("stk_bits", 32'h002, rd);
        chk("stk_hold", 32'h5, {irq, pin_out[9:8]});
        apb(1'b1, 12'h044, 32'h002);
        tk(1);
        chk("stk_clr", 32'h2, {irq, pin_out[9:8]});
    endtask
    task automatic t_alert;
        apb(1'b1, 12'h028, 32'h05);
        apb(1'b1, 12'h04C, 32'h010);
        @(posedge mclk);
        ref_sig_absent <= 8'h01;
        tk(3);
        chk("alert_set", 32'h1, pin_out[10]);
        apb(1'b1, 12'h044, 32'h010);
        tk(1);
        chk("alert_clr", 32'h0, pin_out[10]);
    endtask
    // lock change lands on the very access edge that clears its bit
    task automatic t_race;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= 12'h044;
        pwdata <= 32'h002;
        @(posedge mclk);
        penable <= 1'b1;
        pll_locked <= 4'hD;
        @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        apb(1'b0, 12'h044, 32'h0);
        chk("stk_race", 32'h002, rd);
    endtask
    task automatic end_sim;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #200us;
        err_count++;
        end_sim();
    end
    // main sequence
    initial begin
        {rstn, psel, penable, pwrite, reset_done} = 5'h0;
        {paddr, pwdata, drv} = 60'h0;
        pll_locked = 4'hF;
        ref_sig_absent = 8'h00;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        tk(3);
        @(posedge mclk);
        reset_done <= 1'b1;
        t_input();
        t_output();
        t_live();
        t_sticky();
        t_alert();
        t_race();
        end_sim();
    end
endmodule
